/* File: src/host_port_lock_power_control.sv */
// Host port controller: packets, lock commands, busy line, power-down
`timescale 1ns/10ps
`include "hplc_params.svh"
module host_port_lock_power_control
#(
   parameter int MEM_DEPTH = `HPLC_MEM_DEPTH
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic power_down_req_n_i,
   input wire logic spi_sclk_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_mosi_i,
   output logic spi_miso_o,
   output logic spi_miso_oe_n_o,
   output logic busy_out_n_o,
   output logic busy_oe_n_o
);
   import hplc_pkg::*;

   localparam int AW = $clog2(MEM_DEPTH);
   localparam int PLEN = `HPLC_PROT_LEN;
   localparam int PBASE = `HPLC_PROT_ADDR;
   localparam int HK_CYC_RAW = (`HPLC_HK_TIME_NS * `HPLC_CLK_MHZ + 999) / 1000;
   localparam int HK_CYC = (HK_CYC_RAW < 1) ? 1 : HK_CYC_RAW;
   localparam logic [7:0] HK_LAST = 8'(HK_CYC - 1);
   localparam logic [`HPLC_VERSION_LEN*8-1:0] VER = `HPLC_VERSION_STR;

   typedef struct packed {
      ctl_st_e st;
      logic pd_s1;
      logic pd_s2;
      logic [MEM_DEPTH-1:0][7:0] mem;
      logic locked;
      logic [15:0] addr;
      logic [1:0] bidx;
      logic wflag;
      logic cmd_hit;
      logic [7:0] cnt;
      logic busy_n;
      logic busy_oe_n;
      logic hiz;
   } ctl_s;

   ctl_s s;
   ctl_s next_s;
   logic link_active;
   logic rx_valid;
   logic [7:0] rx_byte;
   logic [7:0] tx_byte;
   logic save;
   logic restore;
   logic [PLEN*8-1:0] nv;
   logic [PLEN*8-1:0] work;
   logic [PLEN*8-1:0] params;
   logic [63:0] pwd_given;
   logic [63:0] pwd_stored;
   logic pwd_match;

   // ****************************************************************
   // Memory helpers
   // ****************************************************************
   function automatic logic in_prot(input logic [15:0] a);
      return (a >= 16'(PBASE)) && (a < 16'(PBASE + PLEN));
   endfunction

   function automatic logic mapped(input logic [15:0] a);
      return a < 16'(MEM_DEPTH);
   endfunction

   function automatic logic [PLEN*8-1:0] region(input logic [MEM_DEPTH-1:0][7:0] m,
                                                input int base);
      logic [PLEN*8-1:0] v;
      v = '0;
      for (int i = 0; i < PLEN; i++)
      begin
         v[i*8 +: 8] = m[base + i];
      end
      return v;
   endfunction

   // Locked protected bytes read as zero
   function automatic logic [7:0] rd_byte(input logic [MEM_DEPTH-1:0][7:0] m,
                                          input logic lk, input logic [15:0] a);
      if (!mapped(a) || (lk && in_prot(a)))
      begin
         return 8'h00;
      end
      return m[a[AW-1:0]];
   endfunction

   // ****************************************************************
   // Serial link and non-volatile store
   // ****************************************************************
   spi_slave_link u_link
   (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .en_i(~s.hiz),
      .sclk_i(spi_sclk_i),
      .cs_n_i(spi_cs_n_i),
      .mosi_i(spi_mosi_i),
      .tx_byte_i(tx_byte),
      .miso_o(spi_miso_o),
      .miso_oe_n_o(spi_miso_oe_n_o),
      .active_o(link_active),
      .rx_valid_o(rx_valid),
      .rx_byte_o(rx_byte)
   );

   protected_store #(.BYTES(PLEN)) u_store
   (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .save_i(save),
      .save_data_i(work),
      .restore_i(restore),
      .nv_o(nv)
   );

   // First three returned bytes are filler
   assign tx_byte = (s.bidx != 2'h3) ? 8'h00 : rd_byte(s.mem, s.locked, s.addr);
   assign work = region(s.mem, PBASE);
   assign params = region(s.mem, int'(`HPLC_PARAM_ADDR));
   assign pwd_given = params[63:0];
   assign pwd_stored = s.locked ? nv[`HPLC_PWD_OFS*8 +: 64] : work[`HPLC_PWD_OFS*8 +: 64];
   assign pwd_match = (pwd_given == pwd_stored);

   // ****************************************************************
   // Controller
   // ****************************************************************
   always_comb
   begin
      next_s = s;
      save = 1'b0;
      restore = 1'b0;
      next_s.pd_s1 = power_down_req_n_i;
      next_s.pd_s2 = s.pd_s1;
      case (s.st)
         ST_START:
         begin
            // Nothing volatile survives a restart
            next_s.mem = '0;
            next_s.locked = 1'b1;
            next_s.busy_n = 1'b0;
            next_s.busy_oe_n = 1'b0;
            next_s.hiz = 1'b0;
            next_s.cnt = s.cnt + 8'h01;
            if (s.cnt == HK_LAST)
            begin
               next_s.busy_n = 1'b1;
               next_s.cnt = 8'h00;
               next_s.st = ST_IDLE;
            end
         end
         ST_IDLE:
         begin
            if (!s.pd_s2)
            begin
               next_s.busy_n = 1'b0;
               next_s.st = ST_PD_PREP;
            end
            else if (link_active)
            begin
               next_s.bidx = 2'h0;
               next_s.wflag = 1'b0;
               next_s.cmd_hit = 1'b0;
               next_s.st = ST_XFER;
            end
         end
         ST_XFER:
         begin
            // Power-down stays pending until the packet ends
            if (rx_valid)
            begin
               case (s.bidx)
                  2'h0: next_s.addr[7:0] = rx_byte;
                  2'h1: next_s.addr[15:8] = rx_byte;
                  2'h2: next_s.wflag = (rx_byte == `HPLC_WR_FLAG);
                  default:
                  begin
                     if (s.wflag)
                     begin
                        if (mapped(s.addr) && !(s.locked && in_prot(s.addr)))
                        begin
                           next_s.mem[s.addr[AW-1:0]] = rx_byte;
                        end
                        next_s.cmd_hit = s.cmd_hit | (s.addr == `HPLC_CMD_ADDR);
                        next_s.mem[`HPLC_RESULT_ADDR] = `HPLC_RES_BUSY;
                        next_s.busy_n = 1'b0;
                     end
                     next_s.addr = s.addr + 16'h0001;
                  end
               endcase
               if (s.bidx != 2'h3)
               begin
                  next_s.bidx = s.bidx + 2'h1;
               end
            end
            if (!link_active)
            begin
               next_s.busy_n = 1'b0;
               next_s.st = ST_EXEC;
            end
         end
         ST_EXEC:
         begin
            next_s.cnt = 8'h00;
            next_s.st = ST_DONE;
            if (s.cmd_hit)
            begin
               next_s.mem[`HPLC_RESULT_ADDR] = `HPLC_RES_OK;
               case (s.mem[`HPLC_CMD_ADDR])
                  `HPLC_CMD_UNLOCK:
                  begin
                     if (!pwd_match)
                     begin
                        next_s.mem[`HPLC_RESULT_ADDR] = `HPLC_RES_BAD_PWD;
                     end
                     else if (s.locked)
                     begin
                        for (int i = 0; i < PLEN; i++)
                        begin
                           next_s.mem[PBASE + i] = nv[i*8 +: 8];
                        end
                        next_s.locked = 1'b0;
                     end
                  end
                  `HPLC_CMD_LOCK:
                  begin
                     if (!s.locked)
                     begin
                        save = 1'b1;
                        next_s.locked = 1'b1;
                     end
                  end
                  `HPLC_CMD_VERSION:
                  begin
                     for (int i = 0; i < `HPLC_VERSION_LEN; i++)
                     begin
                        next_s.mem[`HPLC_BUF_ADDR + i] = VER[(`HPLC_VERSION_LEN-1-i)*8 +: 8];
                     end
                     next_s.mem[`HPLC_BUF_ADDR + `HPLC_VERSION_LEN] = 8'h00;
                  end
                  `HPLC_CMD_DEFAULTS:
                  begin
                     restore = 1'b1;
                     next_s.mem = '0;
                     next_s.locked = 1'b1;
                  end
                  default: next_s.mem[`HPLC_RESULT_ADDR] = `HPLC_RES_UNSUPPORTED;
               endcase
            end
         end
         ST_DONE:
         begin
            // Housekeeping keeps busy low for a fixed time
            next_s.cnt = s.cnt + 8'h01;
            if (s.cnt == HK_LAST)
            begin
               next_s.busy_n = 1'b1;
               next_s.st = ST_IDLE;
            end
         end
         ST_PD_PREP:
         begin
            next_s.busy_oe_n = 1'b1;
            next_s.hiz = 1'b1;
            next_s.st = ST_PD;
         end
         ST_PD:
         begin
            if (s.pd_s2)
            begin
               next_s.cnt = 8'h00;
               next_s.busy_oe_n = 1'b0;
               next_s.st = ST_START;
            end
         end
         default: next_s.st = ST_START;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         s <= '0;
         s.st <= ST_START;
         s.locked <= 1'b1;
         s.pd_s1 <= 1'b1;
         s.pd_s2 <= 1'b1;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign busy_out_n_o = s.busy_n;
   assign busy_oe_n_o = s.busy_oe_n;

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_unlock_ok;
      @(posedge clk_i) disable iff (!rst_n_i)
      (s.st == ST_EXEC && s.cmd_hit && s.mem[1] == 8'h1b && s.locked && pwd_match)
         |=> !s.locked && (s.mem[PBASE] == $past(nv[7:0]));
   endproperty
   a_unlock_ok: assert property (p_unlock_ok)
      else $error("unlock with right password failed");

   property p_unlock_bad;
      @(posedge clk_i) disable iff (!rst_n_i)
      (s.st == ST_EXEC && s.cmd_hit && s.mem[1] == 8'h1b && !pwd_match)
         |=> $stable(s.locked) && (s.mem[0] == 8'h01);
   endproperty
   a_unlock_bad: assert property (p_unlock_bad)
      else $error("wrong password changed lock state");

   property p_lock;
      @(posedge clk_i) disable iff (!rst_n_i)
      (s.st == ST_EXEC && s.cmd_hit && s.mem[1] == 8'h1c && !s.locked)
         |-> save ##1 (s.locked && nv == $past(work));
   endproperty
   a_lock: assert property (p_lock)
      else $error("lock did not save and lock");

   property p_version;
      @(posedge clk_i) disable iff (!rst_n_i)
      (s.st == ST_EXEC && s.cmd_hit && s.mem[1] == 8'h1d)
         |=> (s.mem[16] == 8'h48) && (s.mem[27] == 8'h00);
   endproperty
   a_version: assert property (p_version)
      else $error("version text not written");

   property p_defaults;
      @(posedge clk_i) disable iff (!rst_n_i)
      (s.st == ST_EXEC && s.cmd_hit && s.mem[1] == 8'h1e) |=> s.locked && nv == '0;
   endproperty
   a_defaults: assert property (p_defaults)
      else $error("defaults not restored");

   property p_pd_entry;
      @(posedge clk_i) disable iff (!rst_n_i)
      (s.st == ST_PD_PREP) |-> !busy_out_n_o && !busy_oe_n_o ##1 busy_oe_n_o && s.hiz;
   endproperty
   a_pd_entry: assert property (p_pd_entry)
      else $error("busy not low before sleep");

   property p_pd_defer;
      @(posedge clk_i) disable iff (!rst_n_i)
      (s.st == ST_XFER && link_active) |=> (s.st != ST_PD_PREP) && (s.st != ST_PD);
   endproperty
   a_pd_defer: assert property (p_pd_defer)
      else $error("sleep entered during transfer");

   property p_wake;
      @(posedge clk_i) disable iff (!rst_n_i)
      (s.st == ST_PD && s.pd_s2) |=> !busy_out_n_o ##[1:300] busy_out_n_o;
   endproperty
   a_wake: assert property (p_wake)
      else $error("start-up busy sequence wrong");

   property p_write_busy;
      @(posedge clk_i) disable iff (!rst_n_i)
      (s.st == ST_XFER && rx_valid && s.bidx == 2'h3 && s.wflag)
         |=> !busy_out_n_o && (s.mem[0] == 8'hff);
   endproperty
   a_write_busy: assert property (p_write_busy)
      else $error("write did not raise busy");

   property p_locked_read;
      @(posedge clk_i) disable iff (!rst_n_i)
      (s.locked && in_prot(s.addr)) |-> tx_byte == 8'h00;
   endproperty
   a_locked_read: assert property (p_locked_read)
      else $error("protected byte shown while locked");

   property p_read_busy;
      @(posedge clk_i) disable iff (!rst_n_i)
      (s.st == ST_XFER && !link_active) |=> !busy_out_n_o [*2];
   endproperty
   a_read_busy: assert property (p_read_busy)
      else $error("no busy after packet");

endmodule

/* File: src/hplc_params.svh */
// Constants of the host port lock and power control block
// Summary of operation
// - Unlock 0x1B takes 8-byte LSB-first password
// - Matching password opens protected region
// - Lock 0x1C saves region, then blocks it
// - Version 0x1D writes zero-ended text to buffer
// - Defaults 0x1E restores all memory, drops secrets
// - Power-down low: prepare, busy low, then sleep
// - Wake: restart, busy low, then release high
// - Power-down waits for transfer or command end
// - Asleep: pins high impedance, inputs ignored
// - Power-up locked, default password all zero
// - Locked: protected reads hidden, writes dropped
// - Unlock copies non-volatile region into working copy
// - Commands use working copy unlocked, else stored
// - Host memory write: busy low, result 0xFF
// - Clock idles high; out on fall, in rise
// - Frames are eight bits, MSB first
// - Data output driven only during a transfer
// - Packet: address low, high, write flag first
// - Processing after deselect; busy low even reads
`ifndef HPLC_PARAMS_SVH
`define HPLC_PARAMS_SVH

// ****************************************************************
// Memory map
// ****************************************************************
`define HPLC_RESULT_ADDR 16'h0000
`define HPLC_CMD_ADDR 16'h0001
`define HPLC_PARAM_ADDR 16'h0002
`define HPLC_BUF_ADDR 16'h0010
`define HPLC_PROT_ADDR 16'h0020
`define HPLC_PROT_LEN 16
`define HPLC_PWD_OFS 8
`define HPLC_PWD_LEN 8
`define HPLC_MEM_DEPTH 64
`define HPLC_PWD_DEFAULT 64'h0000000000000000

// ****************************************************************
// Commands, flags and result codes
// ****************************************************************
`define HPLC_CMD_UNLOCK 8'h1b
`define HPLC_CMD_LOCK 8'h1c
`define HPLC_CMD_VERSION 8'h1d
`define HPLC_CMD_DEFAULTS 8'h1e
`define HPLC_WR_FLAG 8'h01
`define HPLC_RES_BUSY 8'hff
`define HPLC_RES_OK 8'h00
`define HPLC_RES_BAD_PWD 8'h01
`define HPLC_RES_UNSUPPORTED 8'h02
`define HPLC_VERSION_STR "HW1.0 FW1.0"
`define HPLC_VERSION_LEN 11

// ****************************************************************
// Timing
// ****************************************************************
`define HPLC_CLK_MHZ 125
`define HPLC_HK_TIME_NS 200

`endif

/* File: src/hplc_pkg.sv */
// Types of the host port lock and power control block
package hplc_pkg;

   // ****************************************************************
   // Controller states, Gray coded along the path from ST_START to ST_DONE
   // ****************************************************************
   typedef enum logic [2:0] {
      ST_START = 3'b000,
      ST_IDLE = 3'b001,
      ST_XFER = 3'b011,
      ST_EXEC = 3'b010,
      ST_DONE = 3'b110,
      ST_PD_PREP = 3'b111,
      ST_PD = 3'b101
   } ctl_st_e;

endpackage

/* File: src/spi_slave_link.sv */
// Serial slave link: samples the host clock, shifts bytes both ways
`timescale 1ns/10ps
module spi_slave_link
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic en_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic mosi_i,
   input wire logic [7:0] tx_byte_i,
   output logic miso_o,
   output logic miso_oe_n_o,
   output logic active_o,
   output logic rx_valid_o,
   output logic [7:0] rx_byte_o
);
   import hplc_pkg::*;

   typedef struct packed {
      logic sck1;
      logic sck2;
      logic sck3;
      logic cs1;
      logic cs2;
      logic mo1;
      logic mo2;
      logic [2:0] cnt;
      logic [7:0] sh_rx;
      logic [7:0] sh_tx;
      logic miso;
      logic oe_n;
      logic active;
      logic rx_valid;
      logic [7:0] rx_byte;
   } link_s;

   link_s s;
   link_s next_s;

   // ****************************************************************
   // Edge finding and shifting
   // ****************************************************************
   // Oversampling at 125 MHz is only safe for a slow host clock
   always_comb
   begin
      next_s = s;
      next_s.sck1 = sclk_i;
      next_s.sck2 = s.sck1;
      next_s.sck3 = s.sck2;
      next_s.cs1 = cs_n_i;
      next_s.cs2 = s.cs1;
      next_s.mo1 = mosi_i;
      next_s.mo2 = s.mo1;
      next_s.rx_valid = 1'b0;
      next_s.active = en_i & ~s.cs2;
      next_s.oe_n = ~next_s.active;
      if (!s.active)
      begin
         next_s.cnt = 3'h0;
      end
      else if (s.sck2 && !s.sck3)
      begin
         // Rising edge samples, MSB first
         next_s.sh_rx = {s.sh_rx[6:0], s.mo2};
         next_s.cnt = s.cnt + 3'h1;
         if (s.cnt == 3'h7)
         begin
            next_s.rx_valid = 1'b1;
            next_s.rx_byte = {s.sh_rx[6:0], s.mo2};
         end
      end
      else if (!s.sck2 && s.sck3)
      begin
         // Falling edge changes the output bit
         if (s.cnt == 3'h0)
         begin
            next_s.miso = tx_byte_i[7];
            next_s.sh_tx = {tx_byte_i[6:0], 1'b0};
         end
         else
         begin
            next_s.miso = s.sh_tx[7];
            next_s.sh_tx = {s.sh_tx[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         s <= '0;
         s.sck1 <= 1'b1;
         s.sck2 <= 1'b1;
         s.sck3 <= 1'b1;
         s.cs1 <= 1'b1;
         s.cs2 <= 1'b1;
         s.oe_n <= 1'b1;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign miso_o = s.miso;
   assign miso_oe_n_o = s.oe_n;
   assign active_o = s.active;
   assign rx_valid_o = s.rx_valid;
   assign rx_byte_o = s.rx_byte;

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_oe_idle;
      @(posedge clk_i) disable iff (!rst_n_i)
      s.cs2 |=> miso_oe_n_o;
   endproperty
   a_oe_idle: assert property (p_oe_idle)
      else $error("data output driven outside a transfer");

   property p_byte_len;
      @(posedge clk_i) disable iff (!rst_n_i)
      (rx_valid_o && s.active) |-> (s.cnt == 3'h0) && ($past(s.cnt) == 3'h7);
   endproperty
   a_byte_len: assert property (p_byte_len)
      else $error("byte strobe not after eight bits");

endmodule

/* File: src/protected_store.sv */
// Non-volatile copy of the protected region
`timescale 1ns/10ps
module protected_store
#(
   parameter int BYTES = 16,
   parameter logic [BYTES*8-1:0] DEFAULTS = '0
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic save_i,
   input wire logic [BYTES*8-1:0] save_data_i,
   input wire logic restore_i,
   output logic [BYTES*8-1:0] nv_o
);
   import hplc_pkg::*;

   typedef struct packed {
      logic [BYTES*8-1:0] nv;
   } store_s;

   store_s s;
   store_s next_s;

   // ****************************************************************
   // Storage
   // ****************************************************************
   // Survives power-down; only the block reset stands for power loss
   always_comb
   begin
      next_s = s;
      if (restore_i)
      begin
         next_s.nv = DEFAULTS;
      end
      else if (save_i)
      begin
         next_s.nv = save_data_i;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         s.nv <= DEFAULTS;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign nv_o = s.nv;

endmodule

/* File: verification/host_spi_model.sv */
// Host serial master model driving the packet protocol
`timescale 1ns/10ps
module host_spi_model
(
   output logic sclk_o,
   output logic cs_n_o,
   output logic mosi_o,
   input wire logic miso_i
);
   logic [7:0] din [16];
   logic [7:0] dout [16];
   logic [7:0] hdr [3];
   logic [7:0] rx;
   initial
   begin
      sclk_o = 1'b1;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   // Bit time 80 ns; clock stands high outside frames
   task automatic xbyte(input logic [7:0] tx);
      for (int b = 7; b >= 0; b--)
      begin
         sclk_o = 1'b0;
         mosi_o = tx[b];
         #40;
         rx[b] = miso_i;
         sclk_o = 1'b1;
         #40;
      end
   endtask
   task automatic packet(input logic [15:0] a, input logic w, input int n);
      hdr = '{a[7:0], a[15:8], {7'h00, w}};
      cs_n_o = 1'b0;
      #200;
      for (int i = 0; i < 3; i++)
         xbyte(hdr[i]);
      for (int i = 0; i < n; i++)
      begin
         xbyte(din[i]);
         dout[i] = rx;
      end
      cs_n_o = 1'b1;
      // Released line must not keep its last value
      mosi_o = ~mosi_o;
      #40;
   endtask
endmodule

/* File: verification/tb.sv */
// Self-checking bench: packets, lock commands, version, defaults, power-down
`timescale 1ns/10ps
`include "hplc_params.svh"
module tb;
   logic clk_i, rst_n_i, pd_n, miso, miso_oe_n, busy_n, busy_oe_n, busy_seen;
   logic miso_last = 1'b0;
   wire logic sclk, cs_n, mosi, miso_w;
   int n_mismatch = 0;
   int cmp_count = 0;
   logic [63:0] pwd;
   assign miso_w = miso_oe_n ? ~miso_last : miso;
   always @(posedge clk_i)
      if (!miso_oe_n)
         miso_last <= miso;
   always @(negedge clk_i)
      if (busy_n === 1'b0)
         busy_seen = 1'b1;
   host_port_lock_power_control dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .power_down_req_n_i(pd_n), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi),
      .spi_miso_o(miso), .spi_miso_oe_n_o(miso_oe_n), .busy_out_n_o(busy_n),
      .busy_oe_n_o(busy_oe_n));
   host_spi_model host_u (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso_w));
   initial
   begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   // ****************************************************************
   // Helpers
   // ****************************************************************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("tests done: %0d compares, %0d mismatches", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   function automatic logic [7:0] exp_ver(input int i);
      string s;
      s = `HPLC_VERSION_STR;
      return (i < s.len()) ? s[i] : 8'h00;
   endfunction
   // Bounded wait; busy may rise late after long housekeeping
   task automatic wait_ready();
      repeat (8) @(negedge clk_i);
      for (int t = 0; t < 400 && busy_n !== 1'b1; t++)
         @(negedge clk_i);
      check({7'h00, busy_n}, 8'h01);
      check({7'h00, miso_oe_n}, 8'h01);
   endtask
   task automatic pkt(input logic [15:0] a, input logic w, input int n);
      busy_seen = 1'b0;
      host_u.packet(a, w, n);
      wait_ready();
      check({7'h00, busy_seen}, 8'h01);
   endtask
   task automatic cmd(input logic [7:0] c, input logic [63:0] p);
      host_u.din[0] = c;
      for (int i = 0; i < 8; i++)
         host_u.din[i+1] = p[8*i +: 8];
      pkt(16'h0001, 1'b1, 9);
   endtask
   task automatic res(input logic [7:0] e);
      pkt(16'h0000, 1'b0, 1);
      check(host_u.dout[0], e);
   endtask
   task automatic rd(input logic [15:0] a, input logic [63:0] p);
      pkt(a, 1'b0, 8);
      for (int i = 0; i < 8; i++)
         check(host_u.dout[i], p[8*i +: 8]);
   endtask
   task automatic wr(input logic [15:0] a, input logic [63:0] p);
      for (int i = 0; i < 8; i++)
         host_u.din[i] = p[8*i +: 8];
      pkt(a, 1'b1, 8);
   endtask
   // ****************************************************************
   // Tests
   // ****************************************************************
   initial
   begin
      pd_n = 1'b1;
      rst_n_i = 1'b0;
      void'($urandom(88));
      repeat (2) @(negedge clk_i);
      rst_n_i = 1'b1;
      wait_ready();
      pwd = {$urandom, $urandom};
      wr(16'h0028, pwd);
      cmd(`HPLC_CMD_UNLOCK, 64'h0);
      res(`HPLC_RES_OK);
      rd(16'h0028, 64'h0);
      wr(16'h0028, pwd);
      wr(16'h0010, ~pwd);
      // Unmapped write must not alias onto the buffer
      wr(16'h0050, pwd);
      rd(16'h0010, ~pwd);
      cmd(`HPLC_CMD_LOCK, 64'h0);
      res(`HPLC_RES_OK);
      rd(16'h0028, 64'h0);
      cmd(`HPLC_CMD_UNLOCK, ~pwd);
      res(`HPLC_RES_BAD_PWD);
      rd(16'h0028, 64'h0);
      cmd(`HPLC_CMD_UNLOCK, pwd);
      res(`HPLC_RES_OK);
      rd(16'h0028, pwd);
      cmd(`HPLC_CMD_UNLOCK, pwd);
      res(`HPLC_RES_OK);
      $display("lock tests done");
      cmd(`HPLC_CMD_VERSION, 64'h0);
      pkt(16'h0010, 1'b0, 12);
      for (int i = 0; i < 12; i++)
         check(host_u.dout[i], exp_ver(i));
      cmd(8'h33, 64'h0);
      res(`HPLC_RES_UNSUPPORTED);
      cmd(`HPLC_CMD_DEFAULTS, 64'h0);
      cmd(`HPLC_CMD_UNLOCK, 64'h0);
      res(`HPLC_RES_OK);
      rd(16'h0028, 64'h0);
      $display("command tests done");
      // Sleep request in mid-packet; data also shows the wake clears memory
      fork
         wr(16'h0010, pwd);
         begin
            #1000;
            pd_n = 1'b0;
            @(posedge cs_n);
            check({7'h00, busy_oe_n}, 8'h00);
         end
      join
      busy_seen = 1'b0;
      pd_n = 1'b0;
      for (int t = 0; t < 400 && busy_oe_n !== 1'b1; t++)
         @(negedge clk_i);
      check({7'h00, busy_seen}, 8'h01);
      check({6'h00, busy_oe_n, miso_oe_n}, 8'h03);
      pd_n = 1'b1;
      wait_ready();
      rd(16'h0010, 64'h0);
      $display("power tests done");
      close_out();
   end
   initial
   begin
      #400000;
      n_mismatch++;
      close_out();
   end
endmodule
